// ### pkg/mmt_pkg.sv
/*
 * Constants, types and carriers of the six-channel multimode timer.
 * Assumes one 250 MHz system clock and an APB master with 32-bit data.
 */
// Operation
// - Channels 0-1 count system clock, timebase /2../32, or external pin edges.
// - Channels 2-5 count system clock or timebase /2 up to /128.
// - Writing one to start bits starts those channels together.
// - Writing one to stop bits clears enable, stopping those channels together.
// - Auto-reload: overflow loads reload value and raises overflow request.
// - Auto-reload leaves the output level unchanged.
// - Compare-output: counter equal to compare updates output per level select.
// - Level 00 drives low, 01 high, 10 toggles on match.
// - Compare-output raises overflow and event requests.
// - PWM period from reload value, first part length from compare.
// - PWM level 00 low while counter <= compare, else high; 01 inverted.
// - PWM raises only the overflow request.
// - Capture copies the counter into compare/capture on selected pin edges.
// - Capture raises overflow and event requests.
// - External clock sampled each edge; count two edges after sampling.
// - Capture pin sampled each edge; copy two edges after sampling.
// - Capture mode releases the shared pin as an input.
// - Compare-output and PWM drive the shared pin.
// - Compare output changes on the count pulse after the match.
// - PWM output changes on the count pulse after the relation holds.
// - Counter is 16 bits; software counter write also loads reload.
// - Flags clear by writing one; overflow flag sets in every mode.
// - Software output write beats a simultaneous hardware update.
package mmt_pkg;
	localparam int NCH = 6;
	// Register map, byte addresses
	localparam logic [7:0] OFS_STRIDE = 8'h20;
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_CNT = 5'h04;
	localparam logic [4:0] OFS_RLD = 5'h08;
	localparam logic [4:0] OFS_CMP = 5'h0c;
	localparam logic [4:0] OFS_LVL = 5'h10;
	localparam logic [4:0] OFS_OUT = 5'h14;
	localparam logic [4:0] OFS_FLAG = 5'h18;
	localparam logic [7:0] OFS_START = 8'hc0;
	localparam logic [7:0] OFS_STOP = 8'hc4;
	// Field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_CSEL_LSB = 2;
	localparam int FLAG_OVF = 0;
	localparam int FLAG_EVT = 1;
	// Operating modes
	localparam logic [1:0] MODE_ART = 2'h0;
	localparam logic [1:0] MODE_CMO = 2'h1;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [1:0] MODE_CAP = 2'h3;
	// Level select codes
	localparam logic [1:0] LV_LOW = 2'h0;
	localparam logic [1:0] LV_HIGH = 2'h1;
	localparam logic [1:0] LV_TOG = 2'h2;
	localparam logic [1:0] LV_RISE = 2'h0;
	localparam logic [1:0] LV_FALL = 2'h1;
	localparam logic [1:0] LV_BOTH = 2'h2;
	// Count clock select codes
	localparam logic [2:0] CS_SYS = 3'h0;
	localparam logic [2:0] CS_EXT_R = 3'h6;
	localparam logic [2:0] CS_EXT_F = 3'h7;
	// Timebase clock period in system clocks
	localparam logic [7:0] TB_DIV = 8'h04;
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RESP = 2'b01} mmt_apb_st_t;
	typedef struct packed {
		logic [7:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} mmt_apb_req_t;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} mmt_apb_rsp_t;
endpackage : mmt_pkg

// ### src/mmt_top.sv
/*
 * Six 16-bit multimode timer channels with an APB register slave.
 * Assumes pins are asynchronous to CLK and the APB master follows APB.
 */
`timescale 1ns/1ps
module mmt_top (
	// Clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// APB slave
	input mmt_pkg::mmt_apb_req_t APB_IN,
	output mmt_pkg::mmt_apb_rsp_t APB_OUT,
	// External count clocks of channels 0 and 1
	input wire logic [1:0] EXT_CLK_PIN,
	// Shared timer pins
	input wire logic [5:0] IO_PIN_I,
	output logic [5:0] IO_PIN_O,
	output logic [5:0] IO_PIN_OE_N,
	// Interrupt requests, one-cycle pulses
	output logic [5:0] OVF_IRQ,
	output logic [5:0] EVT_IRQ
);
	import mmt_pkg::*;

	typedef struct packed {
		mmt_apb_st_t st;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [5:0] en;
		logic [5:0][1:0] mode;
		logic [5:0][2:0] csel;
		logic [5:0][15:0] cnt;
		logic [5:0][15:0] rld;
		logic [5:0][15:0] cmp;
		logic [5:0][1:0] lvl;
		logic [5:0] outl;
		logic [5:0] oe_n;
		logic [5:0] f_ovf;
		logic [5:0] f_evt;
		logic [5:0] ovf_irq;
		logic [5:0] evt_irq;
		logic [7:0] tb_cnt;
		logic [6:0] pre;
		logic [1:0] ext_s1;
		logic [1:0] ext_s2;
		logic [1:0] ext_s3;
		logic [5:0] cap_s1;
		logic [5:0] cap_s2;
		logic [5:0] cap_s3;
	} mmt_state_t;

	mmt_state_t s_reg;
	mmt_state_t s_next;

	// Count pulse from the clock select code
	function automatic logic sel_tick(input int ch, input logic [2:0] sel,
		input logic tb, input logic [6:0] pre, input logic er,
		input logic ef);
		logic t;
		t = 1'b0;
		case (sel)
			CS_SYS: t = 1'b1;
			3'h1: t = tb & pre[0];
			3'h2: t = tb & (&pre[1:0]);
			3'h3: t = tb & (&pre[2:0]);
			3'h4: t = tb & (&pre[3:0]);
			3'h5: t = tb & (&pre[4:0]);
			CS_EXT_R: t = (ch < 2) ? er : (tb & (&pre[5:0]));
			CS_EXT_F: t = (ch < 2) ? ef : (tb & (&pre[6:0]));
			default: t = 1'b0;
		endcase
		return t;
	endfunction : sel_tick

	// Address decode of the register map
	function automatic logic is_mapped(input logic [7:0] a);
		return (a == OFS_START) || (a == OFS_STOP) ||
			((a[7:5] < 3'h6) && (a[1:0] == 2'h0) && (a[4:0] <= OFS_FLAG));
	endfunction : is_mapped

	logic tb;
	logic acc;
	logic wr;
	logic [2:0] ch;
	logic [4:0] rg;
	logic [31:0] rdv;
	logic [1:0] ext_r;
	logic [1:0] ext_f;
	logic [5:0] cap_r;
	logic [5:0] cap_f;
	logic [5:0] tk;
	logic [5:0] ovf;
	logic [5:0] evt;
	logic [5:0] sw_out;

	// Next state: sync, timebase, APB, channels
	always_comb begin
		s_next = s_reg;
		s_next.ovf_irq = '0;
		s_next.evt_irq = '0;
		tk = '0;
		ovf = '0;
		evt = '0;
		sw_out = '0;
		// Three flip-flops on every pin, edges from the second and third stages
		s_next.ext_s1 = EXT_CLK_PIN;
		s_next.ext_s2 = s_reg.ext_s1;
		s_next.ext_s3 = s_reg.ext_s2;
		s_next.cap_s1 = IO_PIN_I;
		s_next.cap_s2 = s_reg.cap_s1;
		s_next.cap_s3 = s_reg.cap_s2;
		ext_r = s_reg.ext_s2 & ~s_reg.ext_s3;
		ext_f = ~s_reg.ext_s2 & s_reg.ext_s3;
		cap_r = s_reg.cap_s2 & ~s_reg.cap_s3;
		cap_f = ~s_reg.cap_s2 & s_reg.cap_s3;
		// Timebase pulse and shared prescaler
		tb = (s_reg.tb_cnt == TB_DIV - 8'h01);
		s_next.tb_cnt = tb ? 8'h00 : s_reg.tb_cnt + 8'h01;
		if (tb) begin
			s_next.pre = s_reg.pre + 7'h01;
		end
		// APB: one wait state, write lands when pready is seen high
		acc = APB_IN.psel & APB_IN.penable;
		wr = (s_reg.st == ST_RESP) & acc & APB_IN.pwrite & ~s_reg.pslverr;
		ch = APB_IN.paddr[7:5];
		rg = APB_IN.paddr[4:0];
		rdv = '0;
		if (APB_IN.paddr == OFS_START) begin
			rdv[5:0] = s_reg.en;
		end else if (ch < 3'h6) begin
			case (rg)
				OFS_CTRL: rdv[4:0] = {s_reg.csel[ch], s_reg.mode[ch]};
				OFS_CNT: rdv[15:0] = s_reg.cnt[ch];
				OFS_RLD: rdv[15:0] = s_reg.rld[ch];
				OFS_CMP: rdv[15:0] = s_reg.cmp[ch];
				OFS_LVL: rdv[1:0] = s_reg.lvl[ch];
				OFS_OUT: rdv[0] = s_reg.outl[ch];
				OFS_FLAG: rdv[1:0] = {s_reg.f_evt[ch], s_reg.f_ovf[ch]};
				default: rdv = '0;
			endcase
		end
		case (s_reg.st)
			ST_IDLE: begin
				if (acc) begin
					s_next.st = ST_RESP;
					s_next.pready = 1'b1;
					s_next.pslverr = ~is_mapped(APB_IN.paddr);
					s_next.prdata = APB_IN.pwrite ? 32'h0 : rdv;
				end
			end
			ST_RESP: begin
				s_next.st = ST_IDLE;
				s_next.pready = 1'b0;
				s_next.pslverr = 1'b0;
			end
			default: begin
				s_next.st = ST_IDLE;
				s_next.pready = 1'b0;
			end
		endcase
		// Channel engines
		for (int i = 0; i < NCH; i++) begin
			tk[i] = s_reg.en[i] & sel_tick(i, s_reg.csel[i], tb,
				s_reg.pre, ext_r[i % 2], ext_f[i % 2]);
			if (tk[i]) begin
				if (s_reg.cnt[i] == 16'hffff) begin
					s_next.cnt[i] = s_reg.rld[i];
					ovf[i] = 1'b1;
				end else begin
					s_next.cnt[i] = s_reg.cnt[i] + 16'h0001;
				end
				// Output moves on the pulse after the match
				case (s_reg.mode[i])
					MODE_CMO: begin
						if (s_reg.cnt[i] == s_reg.cmp[i]) begin
							evt[i] = 1'b1;
							case (s_reg.lvl[i])
								LV_LOW: s_next.outl[i] = 1'b0;
								LV_HIGH: s_next.outl[i] = 1'b1;
								LV_TOG: s_next.outl[i] = ~s_reg.outl[i];
								default: s_next.outl[i] = s_reg.outl[i];
							endcase
						end
					end
					MODE_PWM: begin
						s_next.outl[i] = (s_reg.cnt[i] <= s_reg.cmp[i]) ~^
							s_reg.lvl[i][0];
					end
					default: s_next.outl[i] = s_reg.outl[i];
				endcase
			end
			// Capture two edges after the pin was first sampled
			if (s_reg.en[i] && s_reg.mode[i] == MODE_CAP &&
				((cap_r[i] && s_reg.lvl[i] != LV_FALL) ||
				(cap_f[i] && s_reg.lvl[i] != LV_RISE))) begin
				s_next.cmp[i] = s_reg.cnt[i];
				evt[i] = 1'b1;
			end
			// Pin direction follows the mode
			s_next.oe_n[i] = (s_reg.mode[i] == MODE_CAP);
			// Software access to this channel
			if (wr && ch == i[2:0]) begin
				case (rg)
					OFS_CTRL: begin
						s_next.mode[i] = APB_IN.pwdata[CTRL_MODE_LSB +: 2];
						s_next.csel[i] = APB_IN.pwdata[CTRL_CSEL_LSB +: 3];
					end
					OFS_CNT: begin
						s_next.cnt[i] = APB_IN.pwdata[15:0];
						s_next.rld[i] = APB_IN.pwdata[15:0];
					end
					OFS_RLD: s_next.rld[i] = APB_IN.pwdata[15:0];
					OFS_CMP: begin
						if (!evt[i] || s_reg.mode[i] != MODE_CAP) begin
							s_next.cmp[i] = APB_IN.pwdata[15:0];
						end
					end
					OFS_LVL: s_next.lvl[i] = APB_IN.pwdata[1:0];
					OFS_OUT: begin
						s_next.outl[i] = APB_IN.pwdata[0];
						sw_out[i] = 1'b1;
					end
					OFS_FLAG: begin
						s_next.f_ovf[i] = s_reg.f_ovf[i] &
							~APB_IN.pwdata[FLAG_OVF];
						s_next.f_evt[i] = s_reg.f_evt[i] &
							~APB_IN.pwdata[FLAG_EVT];
					end
					default: s_next.mode[i] = s_reg.mode[i];
				endcase
			end
		end
		// Hardware set wins over a clear in the same cycle
		s_next.f_ovf = s_next.f_ovf | ovf;
		s_next.f_evt = s_next.f_evt | evt;
		s_next.ovf_irq = ovf;
		s_next.evt_irq = evt;
		// Group start and stop
		if (wr && APB_IN.paddr == OFS_START) begin
			s_next.en = s_reg.en | APB_IN.pwdata[5:0];
		end
		if (wr && APB_IN.paddr == OFS_STOP) begin
			s_next.en = s_reg.en & ~APB_IN.pwdata[5:0];
		end
	end

	// State register
	always_ff @(posedge CLK) begin
		if (SRST) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from the state register
	assign APB_OUT.prdata = s_reg.prdata;
	assign APB_OUT.pready = s_reg.pready;
	assign APB_OUT.pslverr = s_reg.pslverr;
	assign IO_PIN_O = s_reg.outl;
	assign IO_PIN_OE_N = s_reg.oe_n;
	assign OVF_IRQ = s_reg.ovf_irq;
	assign EVT_IRQ = s_reg.evt_irq;

	// Checks on channels 0 to 4 and the bus
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);

	start_sets_a: assert property (wr && APB_IN.paddr == OFS_START
		|=> (s_reg.en & $past(APB_IN.pwdata[5:0])) ==
		$past(APB_IN.pwdata[5:0]))
		else $error("start bits not set");
	stop_clears_a: assert property (wr && APB_IN.paddr == OFS_STOP
		|=> (s_reg.en & $past(APB_IN.pwdata[5:0])) == 6'h00)
		else $error("stop bits not cleared");
	ovf_reload_a: assert property (tk[2] && s_reg.cnt[2] == 16'hffff &&
		!(wr && ch == 3'h2) |=> s_reg.cnt[2] == $past(s_reg.rld[2]) &&
		OVF_IRQ[2] && s_reg.f_ovf[2])
		else $error("overflow did not reload");
	art_hold_a: assert property (s_reg.mode[0] == MODE_ART &&
		!sw_out[0] |=> $stable(IO_PIN_O[0]))
		else $error("output moved in auto-reload");
	cmo_match_a: assert property (tk[3] && s_reg.mode[3] == MODE_CMO &&
		s_reg.lvl[3] == LV_TOG && s_reg.cnt[3] == s_reg.cmp[3] &&
		!sw_out[3] |=> IO_PIN_O[3] != $past(IO_PIN_O[3]) && EVT_IRQ[3])
		else $error("compare toggle missed");
	pwm_level_a: assert property (tk[4] && s_reg.mode[4] == MODE_PWM &&
		s_reg.lvl[4] == LV_LOW && !sw_out[4] |=>
		IO_PIN_O[4] == ($past(s_reg.cnt[4]) > $past(s_reg.cmp[4])))
		else $error("pwm level wrong");
	cap_copy_a: assert property (!IO_PIN_I[1] ##1 IO_PIN_I[1] ##2
		s_reg.en[1] && s_reg.mode[1] == MODE_CAP &&
		s_reg.lvl[1] == LV_RISE
		|=> s_reg.cmp[1] == $past(s_reg.cnt[1]) && EVT_IRQ[1])
		else $error("capture copy not two edges after sampling");
	pin_dir_a: assert property (s_reg.mode[1] == MODE_CAP [*2]
		|-> IO_PIN_OE_N[1])
		else $error("pin driven in capture");
	apb_wait_a: assert property (acc && s_reg.st == ST_IDLE
		|=> APB_OUT.pready ##1 !APB_OUT.pready)
		else $error("apb answer timing");

	ovf_seen_c: cover property (OVF_IRQ[2]);
	cap_seen_c: cover property (s_reg.mode[1] == MODE_CAP && EVT_IRQ[1]);
	pwm_seen_c: cover property (s_reg.mode[4] == MODE_PWM && tk[4] ##1
		$changed(IO_PIN_O[4]));
	ext_seen_c: cover property (s_reg.csel[1] == CS_EXT_F && tk[1]);
endmodule : mmt_top

// ### verif/mmt_pin_model.sv
/*
 * Far-side model of the timer pins: external count clocks and triggers.
 * Assumes the bench calls its tasks and that OE_N low means driving.
 */
`timescale 1ns/1ps
module mmt_pin_model (
	// Clock
	input wire logic CLK,
	// Design side of the shared pins
	input wire logic [5:0] IO_PIN_O,
	input wire logic [5:0] IO_PIN_OE_N,
	// Levels seen by the timer
	output logic [1:0] EXT_CLK_PIN,
	output logic [5:0] IO_PIN_I
);
	logic [5:0] trig_drv;
	// Both lines idle low between pulses
	initial begin
		EXT_CLK_PIN = 2'h0;
		trig_drv = 6'h00;
	end
	// Wire level from whichever party drives it
	assign IO_PIN_I = (IO_PIN_OE_N & trig_drv) | (~IO_PIN_OE_N & IO_PIN_O);
	// Whole count clock pulses, high for hold clocks, low for hold plus one clocks between pulses
	task automatic ext_pulses(input int ch, input int n, input int hold);
		repeat (n) begin
			@(posedge CLK);
			EXT_CLK_PIN[ch] <= 1'b1;
			repeat (hold) @(posedge CLK);
			EXT_CLK_PIN[ch] <= 1'b0;
			repeat (hold) @(posedge CLK);
		end
	endtask : ext_pulses
	// One high pulse on a capture trigger
	task automatic trig_pulse(input int ch, input int hold);
		@(posedge CLK);
		trig_drv[ch] <= 1'b1;
		repeat (hold) @(posedge CLK);
		trig_drv[ch] <= 1'b0;
		repeat (hold) @(posedge CLK);
	endtask : trig_pulse
endmodule : mmt_pin_model

// ### verif/tb.sv
/*
 * Self-checking bench of the six-channel timer over APB.
 * Assumes the pin model sits on the shared and external clock pins.
 */
`timescale 1ns/1ps
module tb;
	import mmt_pkg::*;
	logic CLK, SRST, err;
	mmt_apb_req_t req;
	mmt_apb_rsp_t rsp;
	logic [1:0] ext_clk;
	logic [5:0] pin_i, pin_o, pin_oe_n, ovf, evt, m;
	logic [31:0] rd, c;
	int fails, checks_done, cyc, seed, n, e, t0, h0, o0, ovf_n[6], evt_n[6];
	int hi_n;

	mmt_top uut (.CLK(CLK), .SRST(SRST), .APB_IN(req), .APB_OUT(rsp),
		.EXT_CLK_PIN(ext_clk), .IO_PIN_I(pin_i), .IO_PIN_O(pin_o),
		.IO_PIN_OE_N(pin_oe_n), .OVF_IRQ(ovf), .EVT_IRQ(evt));
	mmt_pin_model pins (.CLK(CLK), .IO_PIN_O(pin_o), .IO_PIN_OE_N(pin_oe_n),
		.EXT_CLK_PIN(ext_clk), .IO_PIN_I(pin_i));

	// Clock
	initial begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end
	// Request tallies and hang limit
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		for (int i = 0; i < 6; i++) begin
			if (ovf[i] === 1'b1) ovf_n[i]++;
			if (evt[i] === 1'b1) evt_n[i]++;
		end
		if (pin_o[4] === 1'b1) hi_n++;
		if (cyc == 60000) begin
			fails++;
			final_report();
		end
	end

	task automatic chk(input bit ok, input string msg);
		checks_done++;
		if (!ok) begin
			fails++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask : chk
	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge CLK);
		req.paddr <= a;
		req.pwrite <= w;
		req.pwdata <= d;
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		@(posedge CLK);
		req.penable <= 1'b1;
		k = 0;
		do begin
			@(posedge CLK);
			k++;
		end while (rsp.pready !== 1'b1 && k < 64);
		if (k == 64) chk(1'b0, "no pready");
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb
	function automatic logic [7:0] ra(input int ch, input logic [4:0] o);
		return 8'(ch * 32) + {3'h0, o};
	endfunction : ra
	// Count pulses expected from a clock select over a span of clocks
	function automatic int exp_cnt(input int cs, input int span);
		return (cs == 0) ? span : span / (int'(TB_DIV) << cs);
	endfunction : exp_cnt
	task final_report;
		$display("checks %0d failures %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : final_report

	// Main sequence
	initial begin
		seed = 8359;
		SRST = 1'b1;
		req = '0;
		cyc = 0;
		repeat (10) @(posedge CLK);
		SRST <= 1'b0;
		apb(0, ra(0, OFS_CNT), 0);
		chk(rd === 32'h0, "counter reset");
		apb(0, 8'hc8, 0);
		chk(err === 1'b1, "unmapped");
		// Random channel sets started and stopped together
		repeat (4) begin
			m = 6'($random(seed)) | 6'h01;
			for (int ch = 0; ch < 6; ch++) apb(1, ra(ch, OFS_CNT), 0);
			apb(1, OFS_START, {26'h0, m});
			apb(0, OFS_START, 0);
			chk(rd[5:0] === m, "start bits");
			repeat (($random(seed) & 15) + 2) @(posedge CLK);
			apb(1, OFS_STOP, {26'h0, m});
			apb(0, OFS_START, 0);
			chk(rd[5:0] === 6'h00, "stop bits");
			apb(0, ra(0, OFS_CNT), 0);
			c = rd;
			repeat (20) @(posedge CLK);
			for (int ch = 0; ch < 6; ch++) begin
				apb(0, ra(ch, OFS_CNT), 0);
				chk(rd === (m[ch] ? c : 32'h0), "unison");
			end
		end
		// Count clock selects on a pin channel and a plain channel
		for (int ch = 0; ch < 6; ch += 5)
			for (int cs = 0; cs < (ch == 0 ? 6 : 8); cs++) begin
				apb(1, ra(ch, OFS_CTRL), 32'(cs << 2));
				apb(1, ra(ch, OFS_CNT), 0);
				apb(1, OFS_START, 32'h1 << ch);
				t0 = cyc;
				repeat (1024) @(posedge CLK);
				apb(1, OFS_STOP, 32'h1 << ch);
				e = exp_cnt(cs, cyc - t0);
				apb(0, ra(ch, OFS_CNT), 0);
				chk(rd[15:0] >= 16'(e - 1) && rd[15:0] <= 16'(e + 1), "div");
			end
		// External clock edges, rising on channel 0, falling on 1
		for (int ch = 0; ch < 2; ch++) begin
			apb(1, ra(ch, OFS_CTRL), {27'h0, ch ? CS_EXT_F : CS_EXT_R, 2'h0});
			apb(1, ra(ch, OFS_CNT), 0);
			apb(1, OFS_START, 32'h1 << ch);
			n = 3 + ($random(seed) & 3);
			pins.ext_pulses(ch, n, 2 + ($random(seed) & 1));
			repeat (4) @(posedge CLK);
			apb(1, OFS_STOP, 32'h1 << ch);
			apb(0, ra(ch, OFS_CNT), 0);
			chk(rd === 32'(n), "ext count");
		end
		// Auto-reload across overflow, pin left alone, flag clearing
		apb(1, ra(2, OFS_OUT), 1);
		apb(1, ra(2, OFS_CNT), 32'hfff0);
		apb(1, OFS_START, 32'h04);
		t0 = cyc;
		repeat (40) @(posedge CLK);
		apb(1, OFS_STOP, 32'h04);
		n = cyc - t0;
		apb(0, ra(2, OFS_CNT), 0);
		chk(rd[15:0] === 16'hfff0 + 16'(n % 16) && ovf_n[2] == n / 16, "reload");
		chk(pin_o[2] === 1'b1 && evt_n[2] == 0, "art pin");
		apb(1, ra(2, OFS_FLAG), 0);
		apb(0, ra(2, OFS_FLAG), 0);
		chk(rd[FLAG_OVF] === 1'b1, "ovf flag");
		apb(1, ra(2, OFS_FLAG), 32'h1);
		apb(0, ra(2, OFS_FLAG), 0);
		chk(rd === 32'h0, "flag clear");
		// Compare output, each level select
		for (logic [1:0] lv = LV_LOW; lv <= LV_TOG; lv++) begin
			m[0] = (lv == LV_LOW) ? 1'b1 : (lv == LV_HIGH) ? 1'b0 : 1'($random(seed));
			apb(1, ra(3, OFS_CTRL), {30'h0, MODE_CMO});
			apb(1, ra(3, OFS_LVL), {30'h0, lv});
			apb(1, ra(3, OFS_OUT), {31'h0, m[0]});
			apb(1, ra(3, OFS_CMP), 32'h20);
			apb(1, ra(3, OFS_CNT), 0);
			e = evt_n[3];
			apb(1, OFS_START, 32'h08);
			n = 0;
			while (evt_n[3] == e && n < 300) begin
				@(posedge CLK);
				n++;
			end
			chk(n < 300 && pin_oe_n[3] === 1'b0, "match");
			chk(pin_o[3] === ((lv == LV_TOG) ? ~m[0] : lv[0]), "level");
			apb(1, OFS_STOP, 32'h08);
		end
		// Pulse width over ten periods of 32 counts, compare at fff0
		apb(1, ra(4, OFS_CTRL), {30'h0, MODE_PWM});
		apb(1, ra(4, OFS_CMP), 32'hfff0);
		apb(1, ra(4, OFS_CNT), 32'hffe0);
		apb(1, OFS_START, 32'h10);
		for (int lv = 0; lv < 2; lv++) begin
			apb(1, ra(4, OFS_LVL), 32'(lv));
			repeat (64) @(posedge CLK);
			h0 = hi_n;
			o0 = ovf_n[4];
			e = evt_n[4];
			repeat (320) @(posedge CLK);
			n = hi_n - h0 - (lv ? 170 : 150);
			chk(n >= -2 && n <= 2, "duty");
			chk(evt_n[4] == e && ovf_n[4] - o0 >= 9, "pwm irq");
			chk(pin_oe_n[4] === 1'b0, "pwm drives");
		end
		apb(1, OFS_STOP, 32'h10);
		// Capture on each edge choice
		apb(1, ra(1, OFS_CTRL), {30'h0, MODE_CAP});
		apb(1, ra(1, OFS_CNT), 0);
		apb(1, OFS_START, 32'h02);
		chk(pin_oe_n[1] === 1'b1, "cap input");
		for (logic [1:0] lv = LV_RISE; lv <= LV_BOTH; lv++) begin
			apb(1, ra(1, OFS_LVL), {30'h0, lv});
			e = evt_n[1];
			pins.trig_pulse(1, 3);
			repeat (6) @(posedge CLK);
			chk(evt_n[1] - e == (lv == LV_BOTH ? 2 : 1), "cap events");
			apb(0, ra(1, OFS_CMP), 0);
			c = rd;
			apb(0, ra(1, OFS_CNT), 0);
			chk(c !== 32'h0 && c < rd, "cap value");
		end
		apb(1, OFS_STOP, 32'h02);
		final_report();
	end
endmodule : tb
